//--- ddrwd_decoder.sv
/*
  serial write-frame decoder and per-channel data registers.
  assumes the host drives link_sclk, link_sync_n and link_sdin as a
  framed serial link; sys_rst is held while no frame is in flight.
*/
`timescale 1ns/1ps
module ddrwd_decoder (
  input  wire logic               clk,                  // system clock
  input  wire logic               sys_rst,              // reset, high; sync except async on tog_r
  input  wire logic               clk_en,               // freezes state low
  input  wire logic               link_sclk,            // serial clock
  input  wire logic               link_sync_n,          // frame, low active
  input  wire logic               link_sdin,            // serial data
  input  wire logic               packet_check_enable,  // 32-bit frames
  input  wire logic               address_pin_hi,       // device addr pin
  input  wire logic               address_pin_lo,       // device addr pin
  input  wire logic               clear_pin,            // clear, high
  output ddrwd_pkg::ddrwd_bank_t  code_r,               // output codes
  output ddrwd_pkg::ddrwd_bank_t  gain_r,               // gain trims
  output ddrwd_pkg::ddrwd_bank_t  offs_r,               // offset trims
  output ddrwd_pkg::ddrwd_bank_t  clrv_r,               // clear values
  output logic [3:0]              clear_value_enable_r, // per channel
  output logic                    ctrl_stb_r,           // control write
  output logic [2:0]              ctrl_sel_r,           // control select
  output logic [1:0]              ctrl_ch_r,            // control channel
  output logic [12:0]             ctrl_data_r           // control payload
);

  // keeps data bits 15..4 and fills the low nibble
  function automatic logic [15:0] fill12(input logic [15:0] d,
                                         input logic [3:0]  low);
    fill12 = {d[ddrwd_pkg::DATA_HI:ddrwd_pkg::DATA_LO], low};
  endfunction

  // ---------------- link domain ----------------
  logic [ddrwd_pkg::CNT_W-1:0] bit_cnt_r;
  logic [ddrwd_pkg::CNT_W-1:0] bit_cnt_nxt;
  logic [31:0]                 shift_r;
  logic [23:0]                 word_r;
  logic                        tog_r;
  logic                        pec_m_r;
  logic                        pec_s_r;
  logic [ddrwd_pkg::CNT_W-1:0] last_bit;

  // check-code enable pin through two flops on the link clock
  always_ff @(negedge link_sclk) begin
    pec_m_r <= packet_check_enable;
    pec_s_r <= pec_m_r;
  end

  // last bit index of the frame, chosen by frame length
  always_comb begin
    last_bit = pec_s_r ? ddrwd_pkg::CNT_W'(ddrwd_pkg::PEC_BITS - 1)
                       : ddrwd_pkg::CNT_W'(ddrwd_pkg::CMD_BITS - 1);
    bit_cnt_nxt = bit_cnt_r + ddrwd_pkg::CNT_W'(1);
  end

  // bit counter and shifter, cleared whenever the frame is idle
  always_ff @(negedge link_sclk or posedge link_sync_n) begin
    if (link_sync_n) begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
    end else begin
      shift_r <= {shift_r[30:0], link_sdin};
      if (bit_cnt_r <= last_bit) begin
        bit_cnt_r <= bit_cnt_nxt;
      end
    end
  end

  // command word catch at bit 24; the check byte is shifted past
  always_ff @(negedge link_sclk) begin
    if (!link_sync_n &&
        bit_cnt_r == ddrwd_pkg::CNT_W'(ddrwd_pkg::CMD_BITS - 1)) begin
      word_r <= {shift_r[22:0], link_sdin};
    end
  end

  // frame-done toggle, flips on the last bit of a full frame
  always_ff @(negedge link_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_r <= 1'b0;
    end else if (!link_sync_n && bit_cnt_r == last_bit) begin
      tog_r <= ~tog_r;
    end
  end

  // ---------------- system domain ----------------
  logic                   tog_m_r;
  logic                   tog_s_r;
  logic                   tog_p_r;
  logic [1:0]             addr_m_r;
  logic [1:0]             addr_s_r;
  logic                   clr_m_r;
  logic                   clr_s_r;
  logic                   fr_stb;
  ddrwd_pkg::ddrwd_frame_s fr;
  logic [1:0]             ch;
  logic                   dev_hit;
  logic                   wr_hit;

  // toggle, address pins and clear pin through two flops each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tog_m_r  <= 1'b0;
      tog_s_r  <= 1'b0;
      tog_p_r  <= 1'b0;
      addr_m_r <= 2'h0;
      addr_s_r <= 2'h0;
      clr_m_r  <= 1'b0;
      clr_s_r  <= 1'b0;
    end else if (clk_en) begin
      tog_m_r  <= tog_r;
      tog_s_r  <= tog_m_r;
      tog_p_r  <= tog_s_r;
      addr_m_r <= {address_pin_hi, address_pin_lo};
      addr_s_r <= addr_m_r;
      clr_m_r  <= clear_pin;
      clr_s_r  <= clr_m_r;
    end
  end

  // frame decode; word_r is stable long before the next frame ends
  // group 001 matches no register process, so it changes nothing
  always_comb begin
    fr      = ddrwd_pkg::ddrwd_frame_s'(word_r);
    fr_stb  = clk_en & (tog_s_r ^ tog_p_r);
    ch      = {fr.channel_select_hi, fr.channel_select_lo};
    dev_hit = ({fr.device_select_hi, fr.device_select_lo}
               == addr_s_r);
    wr_hit  = fr_stb & dev_hit & ~fr.read_flag;
  end

  // gain trim registers, one channel or all at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gain_r <= {ddrwd_pkg::NUM_CH{ddrwd_pkg::GAIN_RST}};
    end else if (wr_hit) begin
      if (fr.register_group_select == ddrwd_pkg::GRP_GAIN_ONE) begin
        gain_r[ch] <= fill12(fr.data, ddrwd_pkg::GAIN_LOW);
      end else if (fr.register_group_select == ddrwd_pkg::GRP_GAIN_ALL)
      begin
        gain_r <= {ddrwd_pkg::NUM_CH{fill12(fr.data,
                                            ddrwd_pkg::GAIN_LOW)}};
      end
    end
  end

  // offset trim registers, midscale means no adjustment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offs_r <= {ddrwd_pkg::NUM_CH{ddrwd_pkg::OFFS_RST}};
    end else if (wr_hit) begin
      if (fr.register_group_select == ddrwd_pkg::GRP_OFFS_ONE) begin
        offs_r[ch] <= fill12(fr.data, ddrwd_pkg::ZERO_LOW);
      end else if (fr.register_group_select == ddrwd_pkg::GRP_OFFS_ALL)
      begin
        offs_r <= {ddrwd_pkg::NUM_CH{fill12(fr.data,
                                            ddrwd_pkg::ZERO_LOW)}};
      end
    end
  end

  // clear value registers, selected channel only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clrv_r <= {ddrwd_pkg::NUM_CH{ddrwd_pkg::CLRV_RST}};
    end else if (wr_hit &&
                 fr.register_group_select == ddrwd_pkg::GRP_CLRV) begin
      clrv_r[ch] <= fill12(fr.data, ddrwd_pkg::ZERO_LOW);
    end
  end

  // control routing: strobe, select field and payload for outside logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_stb_r  <= 1'b0;
      ctrl_sel_r  <= 3'h0;
      ctrl_ch_r   <= 2'h0;
      ctrl_data_r <= 13'h0000;
    end else if (clk_en) begin
      ctrl_stb_r <= wr_hit &
                    (fr.register_group_select == ddrwd_pkg::GRP_CTRL);
      if (wr_hit && fr.register_group_select == ddrwd_pkg::GRP_CTRL) begin
        ctrl_sel_r  <= fr.data[ddrwd_pkg::CSEL_HI:ddrwd_pkg::CSEL_LO];
        ctrl_ch_r   <= ch;
        ctrl_data_r <= fr.data[12:0];
      end
    end
  end

  // clear enable bits, kept from per-channel control writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clear_value_enable_r <= 4'h0;
    end else if (wr_hit &&
                 fr.register_group_select == ddrwd_pkg::GRP_CTRL &&
                 fr.data[ddrwd_pkg::CSEL_HI:ddrwd_pkg::CSEL_LO]
                   == ddrwd_pkg::CSEL_DACCTL) begin
      clear_value_enable_r[ch] <= fr.data[ddrwd_pkg::CLEAR_VALUE_ENABLE_BIT];
    end
  end

  // output codes; a held clear overrides writes on enabled channels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      code_r <= {ddrwd_pkg::NUM_CH{ddrwd_pkg::CODE_RST}};
    end else if (clk_en) begin
      for (int i = 0; i < ddrwd_pkg::NUM_CH; i++) begin
        if (clr_s_r && clear_value_enable_r[i]) begin
          code_r[i] <= clrv_r[i];
        end else if (wr_hit && ch == 2'(i) &&
                     fr.register_group_select == ddrwd_pkg::GRP_CODE) begin
          code_r[i] <= fill12(fr.data, ddrwd_pkg::ZERO_LOW);
        end
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk iff clk_en); endclocking
  default disable iff (sys_rst);

  sequence s_write(ddrwd_pkg::ddrwd_grp_e g);
    wr_hit && fr.register_group_select == g;
  endsequence

  sequence s_all_still;
    $stable(gain_r) && $stable(offs_r) && $stable(clrv_r);
  endsequence

  AST_RST_VALUES: assert property (disable iff (1'b0)
    sys_rst |=> gain_r == {4{ddrwd_pkg::GAIN_RST}} &&
                offs_r == {4{ddrwd_pkg::OFFS_RST}} &&
                clrv_r == {4{ddrwd_pkg::CLRV_RST}})
    else $error("register reset values wrong");
  AST_READ_IGNORED: assert property (
    fr_stb && fr.read_flag |=> s_all_still)
    else $error("read frame changed a register");
  AST_DEV_MISMATCH: assert property (
    fr_stb && !dev_hit |=> s_all_still)
    else $error("frame for another device changed a register");
  AST_RESERVED: assert property (
    s_write(ddrwd_pkg::GRP_RSVD) |=> s_all_still and $stable(code_r))
    else $error("reserved group changed a register");
  AST_GAIN_ONE: assert property (
    s_write(ddrwd_pkg::GRP_GAIN_ONE) |=>
      gain_r[$past(ch)] == {$past(fr.data[15:4]), 4'hF} && $stable(offs_r))
    else $error("single gain write wrong");
  AST_GAIN_ALL: assert property (
    s_write(ddrwd_pkg::GRP_GAIN_ALL) |=>
      gain_r == {4{$past(fr.data[15:4]), 4'hF}})
    else $error("broadcast gain write wrong");
  AST_OFFS_ALL: assert property (
    s_write(ddrwd_pkg::GRP_OFFS_ALL) |=>
      offs_r == {4{$past(fr.data[15:4]), 4'h0}})
    else $error("broadcast offset write wrong");
  AST_CLRV_ONE: assert property (
    s_write(ddrwd_pkg::GRP_CLRV) |=>
      clrv_r[$past(ch)] == {$past(fr.data[15:4]), 4'h0} && $stable(gain_r))
    else $error("clear value write wrong");
  AST_CTRL_ROUTE: assert property (
    s_write(ddrwd_pkg::GRP_CTRL) |=>
      ctrl_stb_r && ctrl_sel_r == $past(fr.data[15:13]) ##1 !ctrl_stb_r)
    else $error("control write not routed");
  AST_CODE_WRITE: assert property (
    s_write(ddrwd_pkg::GRP_CODE) and !clr_s_r |=>
      code_r[$past(ch)] == {$past(fr.data[15:4]), 4'h0})
    else $error("code write wrong");
  AST_CLEAR_A: assert property (
    clr_s_r && clear_value_enable_r[0] |=> code_r[0] == $past(clrv_r[0]))
    else $error("clear did not load channel A");
  AST_NO_CLEAR_A: assert property (
    clr_s_r && !clear_value_enable_r[0] && !wr_hit |=> $stable(code_r[0]))
    else $error("disabled channel A took the clear value");

  // single offset write, clear enable capture and strobe origin
  AST_OFFS_ONE: assert property (
    s_write(ddrwd_pkg::GRP_OFFS_ONE) |=>
      offs_r[$past(ch)] == {$past(fr.data[15:4]), 4'h0} && $stable(gain_r))
    else $error("single offset write wrong");
  AST_CLEAR_VALUE_ENABLE_TAKEN: assert property (
    s_write(ddrwd_pkg::GRP_CTRL) and
    fr.data[15:13] == ddrwd_pkg::CSEL_DACCTL |=>
      clear_value_enable_r[$past(ch)] == $past(fr.data[2]))
    else $error("clear enable not taken from control write");
  AST_STB_SOURCE: assert property (
    ctrl_stb_r |-> $past(wr_hit) &&
      $past(fr.register_group_select) == ddrwd_pkg::GRP_CTRL)
    else $error("control strobe without a control write");

  // clear held on enabled channel B keeps loading its clear value
  sequence s_clear_b;
    clr_s_r && clear_value_enable_r[1];
  endsequence
  AST_CLEAR_B: assert property (
    s_clear_b |=> code_r[1] == $past(clrv_r[1]))
    else $error("clear did not load channel B");

endmodule

//--- ddrwd_host.sv
/*
  host-side model of the serial write link: frames of up to 32 bits (the bench sends 16, 24 and 32),
  msb first, link clock idle high between frames, pulsed there only by idle_clocks.
  assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module ddrwd_host (
  output logic link_sclk,   // serial clock, idle high
  output logic link_sync_n, // frame strobe, low active
  output logic link_sdin    // serial data
);
  localparam realtime HALF = 24.0; // half of a 48 ns link period

  // idle levels before any frame
  initial begin
    link_sclk = 1'b1;
    link_sync_n = 1'b1;
    link_sdin = 1'b0;
  end

  // clock pulses with no frame open, so mode inputs get synced
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #HALF link_sclk = 1'b0;
      #HALF link_sclk = 1'b1;
    end
  endtask

  // data moves on the rise, the device samples on the fall
  task automatic send(input logic [31:0] word, input int nbits);
    int i;
    link_sync_n = 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      link_sdin = word[i];
      #HALF link_sclk = 1'b0;
      #HALF link_sclk = 1'b1;
    end
    #HALF link_sync_n = 1'b1;
    link_sdin = ~link_sdin; // no stale bit after release
    #(2 * HALF);
  endtask
endmodule

//--- ddrwd_pkg.sv
/*
  shared constants and types for the quad-channel data register write
  decoder: frame layout, register-group codes, reset values, field spots.
  assumes a 24-bit command frame, 32 bits when the check code is enabled.
*/
// What this block does
// - a frame is 24 bits, or 32 with the trailing check code enabled.
// - top byte: rw, two device bits, three group bits, two channel bits.
// - top bit zero means write; one means read, so nothing is written.
// - act only when device select bits equal the two address pins.
// - group 000 writes data bits 15 to 4 into the channel code.
// - channel bits 00..11 pick A..D; ignored for all-channel writes.
// - group 010 loads the gain trim of the selected channel only.
// - group 011 loads the same gain trim into all four channels.
// - gain trim is straight binary and resets to all ones.
// - group 100 loads the offset trim of the selected channel only.
// - group 101 loads the same offset trim into all four channels.
// - offset trim is straight binary, midscale gives zero adjustment.
// - offset trim resets to the zero-offset code.
// - group 110 loads the clear value of the selected channel.
// - every clear value resets to zero.
// - clear pin loads clear value only where that channel's enable is set.
// - group 111 routes the frame to a control register.
// - control register select sits in data bits 15 down to 13.
package ddrwd_pkg;
  localparam int unsigned CMD_BITS  = 24;
  localparam int unsigned PEC_BITS  = 32;
  localparam int unsigned CNT_W     = 6;
  localparam int unsigned NUM_CH    = 4;
  localparam logic [15:0] GAIN_RST  = 16'hFFFF;
  localparam logic [15:0] OFFS_RST  = 16'h8000;
  localparam logic [15:0] CLRV_RST  = 16'h0000;
  localparam logic [15:0] CODE_RST  = 16'h0000;
  localparam logic [3:0]  GAIN_LOW  = 4'hF;
  localparam logic [3:0]  ZERO_LOW  = 4'h0;
  localparam int unsigned DATA_HI   = 15;
  localparam int unsigned DATA_LO   = 4;
  localparam int unsigned CSEL_HI   = 15;
  localparam int unsigned CSEL_LO   = 13;
  localparam logic [2:0]  CSEL_DACCTL = 3'h2;
  localparam int unsigned CLEAR_VALUE_ENABLE_BIT  = 2;

  typedef enum logic [2:0] {
    GRP_CODE     = 3'b000,
    GRP_RSVD     = 3'b001,
    GRP_GAIN_ONE = 3'b010,
    GRP_GAIN_ALL = 3'b011,
    GRP_OFFS_ONE = 3'b100,
    GRP_OFFS_ALL = 3'b101,
    GRP_CLRV     = 3'b110,
    GRP_CTRL     = 3'b111
  } ddrwd_grp_e;

  typedef struct packed {
    logic       read_flag;
    logic       device_select_hi;
    logic       device_select_lo;
    ddrwd_grp_e register_group_select;
    logic       channel_select_hi;
    logic       channel_select_lo;
    logic [15:0] data;
  } ddrwd_frame_s;

  typedef logic [NUM_CH-1:0][15:0] ddrwd_bank_t;
endpackage

//--- tb_dac_data_register_write_decoder.sv
/*
  self-checking bench for the data register write decoder.
  assumes the host model drives the link; bench drives the rest.
*/
`timescale 1ns/1ps
module tb_dac_data_register_write_decoder;
  logic                   clk, sys_rst, clk_en, pce, ahi, alo, clear_pin;
  logic                   link_sclk, link_sync_n, link_sdin;
  ddrwd_pkg::ddrwd_bank_t code_r, gain_r, offs_r, clrv_r;
  ddrwd_pkg::ddrwd_bank_t e_code, e_gain, e_offs, e_clrv;
  logic [3:0]             cven;
  logic                   ctrl_stb;
  logic [2:0]             csel;
  logic [1:0]             cch;
  logic [12:0]            cdat;
  int                     n_fail, checked, n_stb;

  ddrwd_host host (.link_sclk(link_sclk), .link_sync_n(link_sync_n),
    .link_sdin(link_sdin));
  ddrwd_decoder dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .link_sclk(link_sclk), .link_sync_n(link_sync_n),
    .link_sdin(link_sdin), .packet_check_enable(pce),
    .address_pin_hi(ahi), .address_pin_lo(alo), .clear_pin(clear_pin),
    .code_r(code_r), .gain_r(gain_r), .offs_r(offs_r), .clrv_r(clrv_r),
    .clear_value_enable_r(cven), .ctrl_stb_r(ctrl_stb),
    .ctrl_sel_r(csel), .ctrl_ch_r(cch), .ctrl_data_r(cdat));

  // 50 MHz system clock
  always #10 clk = ~clk;

  // counts control strobes; each is a one-cycle pulse
  always @(negedge clk) begin
    if (ctrl_stb === 1'b1) begin
      n_stb++;
    end
  end

  task automatic chk(input string name, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic banks();
    chk("code", code_r, e_code);
    chk("gain", gain_r, e_gain);
    chk("offs", offs_r, e_offs);
    chk("clrv", clrv_r, e_clrv);
  endtask

  task automatic give_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one 24-bit frame, then room for the sync and register update
  task automatic wr(input logic rd, input logic [1:0] dev,
    input logic [2:0] grp, input logic [1:0] ch, input logic [15:0] d);
    host.send({8'h00, rd, dev, grp, ch, d}, 24);
    repeat (10) @(posedge clk);
  endtask

  // single-channel writes of every data group on every channel
  task automatic t_single();
    logic [15:0] d;
    for (int c = 0; c < 4; c++) begin
      d = 16'(16'h1ABC + 16'h2101 * c);
      wr(1'b0, 2'h2, 3'h0, c[1:0], d);
      e_code[c] = {d[15:4], ddrwd_pkg::ZERO_LOW};
      wr(1'b0, 2'h2, 3'h2, c[1:0],
         16'(16'hC003 + 16'h0110 * c));
      e_gain[c] = {12'(12'hC00 + 12'h011 * c), ddrwd_pkg::GAIN_LOW};
      wr(1'b0, 2'h2, 3'h4, c[1:0], d ^ 16'h8F0F);
      e_offs[c] = {d[15:4] ^ 12'h8F0, ddrwd_pkg::ZERO_LOW};
      wr(1'b0, 2'h2, 3'h6, c[1:0], ~d);
      e_clrv[c] = {~d[15:4], ddrwd_pkg::ZERO_LOW};
    end
    banks();
  endtask

  // all-channel writes ignore the channel bits
  task automatic t_all();
    wr(1'b0, 2'h2, 3'h3, 2'h2, 16'hE5A7);
    e_gain = {4{16'hE5AF}};
    wr(1'b0, 2'h2, 3'h5, 2'h1, 16'h7FF3);
    e_offs = {4{16'h7FF0}};
    banks();
  endtask

  // read, wrong device, reserved group, short frame: nothing changes
  task automatic t_refuse();
    wr(1'b1, 2'h2, 3'h0, 2'h0, 16'h5550);
    wr(1'b0, 2'h1, 3'h0, 2'h0, 16'h6660);
    wr(1'b0, 2'h2, 3'h1, 2'h0, 16'h7770);
    host.send({16'h0000, 8'h08, 8'h00}, 16);
    repeat (10) @(posedge clk);
    banks();
  endtask

  // raise clear for eight cycles, then drop it and let the sync settle
  task automatic pulse_clear();
    @(negedge clk);
    clear_pin = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    clear_pin = 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // enable clear on channel B, pull clear, then add channel A
  task automatic t_ctrl_clear();
    wr(1'b0, 2'h2, 3'h7, 2'h1, {3'b010, 13'h0004});
    chk("csel", csel, 3'b010);
    chk("cch", cch, 2'h1);
    chk("cdat", cdat, 13'h0004);
    chk("cven", cven, 4'b0010);
    chk("stb", n_stb, 1);
    pulse_clear();
    e_code[1] = e_clrv[1];
    chk("code", code_r, e_code);
    wr(1'b0, 2'h2, 3'h7, 2'h0, {3'b010, 13'h0004});
    chk("cven", cven, 4'b0011);
    chk("stb", n_stb, 2);
    pulse_clear();
    e_code[0] = e_clrv[0];
    chk("code", code_r, e_code);
  endtask

  // clock enable low holds every bank register until it returns
  task automatic t_freeze();
    @(negedge clk);
    clk_en = 1'b0;
    wr(1'b0, 2'h2, 3'h2, 2'h0, 16'h3217);
    banks();
    @(negedge clk);
    clk_en = 1'b1;
    repeat (10) @(posedge clk);
    e_gain[0] = 16'h321F;
    banks();
  endtask

  // 32-bit frame with trailing check byte
  task automatic t_pec();
    @(negedge clk);
    pce = 1'b1;
    host.idle_clocks(3);
    host.send({8'h43, 16'hA5C3, 8'h5A}, 32);
    repeat (10) @(posedge clk);
    e_code[3] = 16'hA5C0;
    chk("code", code_r, e_code);
    @(negedge clk);
    pce = 1'b0;
    host.idle_clocks(3);
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    pce = 1'b0;
    {ahi, alo} = 2'h2;
    clear_pin = 1'b0;
    n_fail = 0;
    checked = 0;
    n_stb = 0;
    e_code = '0;
    e_gain = {4{ddrwd_pkg::GAIN_RST}};
    e_offs = {4{ddrwd_pkg::OFFS_RST}};
    e_clrv = {4{ddrwd_pkg::CLRV_RST}};
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    banks();
    t_single();
    t_all();
    t_refuse();
    t_ctrl_clear();
    t_pec();
    t_freeze();
    give_verdict();
  end

  // hang guard
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule
